// ===== spc_chk.sv
`timescale 1ns/1ns
module spc_chk (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       global_irq_en,
    input wire logic       irq,
    input wire logic       sck_out,
    input wire logic       sck_oe,
    input wire logic       mosi_oe,
    input wire logic       miso_oe,
    input wire logic       ss_n_in
);
    logic       en_q;  // shadow of port enable
    logic       ie_q;  // shadow of irq enable
    logic       msk_q; // any mask bit set
    logic       cfg_q; // select pin is input
    logic       sck_q; // clock one cycle ago
    logic [4:0] edg_q; // clock edges since start
    logic [2:0] hi_q;  // select high run
    logic [2:0] lo_q;  // select low run
    default clocking @(posedge ref_clk); endclocking
    // mirror register writes and count runs
    always_ff @(posedge ref_clk) begin
        sck_q <= sck_out;
        hi_q <= (rst || !ss_n_in) ? 3'h0 : hi_q + {2'h0, hi_q != 3'h7};
        lo_q <= (rst || ss_n_in) ? 3'h0 : lo_q + {2'h0, lo_q != 3'h7};
        if (rst) begin
            {en_q, ie_q, msk_q, cfg_q} <= 4'h0;
            edg_q <= 5'h00;
        end else begin
            if (reg_wr && reg_addr == 4'h0) {ie_q, en_q} <= reg_wdata[7:6];
            if (reg_wr && reg_addr == 4'h3) msk_q <= |reg_wdata[1:0];
            if (reg_wr && reg_addr == 4'h5) cfg_q <= reg_wdata[0];
            if (reg_wr && reg_addr inside {4'h0, 4'h2}) edg_q <= 5'h00;
            else if (sck_out != sck_q && edg_q != 5'h1F) edg_q <= edg_q + 5'h01;
        end
    end
    a_reset_quiet: assert property (rst |=> !irq && !sck_out && !sck_oe
        && !mosi_oe && !miso_oe && reg_rdata == 8'h00) else $error("busy after reset");
    a_rdata_idle: assert property (disable iff (rst)
        !reg_rd |=> reg_rdata == 8'h00) else $error("read data without read");
    a_disabled_quiet: assert property (disable iff (rst)
        !en_q |-> !sck_oe && !mosi_oe && !miso_oe) else $error("pins driven while off");
    a_idle_level: assert property (disable iff (rst)
        reg_wr && reg_addr == 4'h0 && reg_wdata[6] && reg_wdata[4]
        |-> ##2 sck_out == $past(reg_wdata[3], 2)) else $error("wrong clock idle level");
    a_irq_cause: assert property (disable iff (rst)
        !(ie_q && global_irq_en) && !msk_q && !reg_wr |=> !irq) else $error("irq without cause");
    a_edge_limit: assert property (disable iff (rst)
        edg_q <= 5'h10) else $error("more than sixteen clock edges");
    a_deselect_tristate: assert property (disable iff (rst)
        hi_q >= 3'h4 |-> !miso_oe) else $error("output driven while deselected");
    a_oe_roles: assert property (disable iff (rst)
        sck_oe == mosi_oe && !(mosi_oe && miso_oe)) else $error("mixed pin roles");
    a_fault_drop: assert property (disable iff (rst)
        cfg_q && lo_q >= 3'h5 |-> !sck_oe) else $error("controller kept after fault");
endmodule
bind spc_port spc_chk u_chk (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .global_irq_en(global_irq_en), .irq(irq), .sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_oe(mosi_oe), .miso_oe(miso_oe), .ss_n_in(ss_n_in));

// ===== spc_map.svh
// Summary of operation
// - interrupt when enabled, done and global enable
// - nothing happens unless port enabled
// - bit order one sends LSB first
// - controller select one means controller mode
// - select low as input forces target, done
// - idle level sets clock idle and edges
// - control register eight bits, zero at reset
// - phase bit picks sample versus setup edge
// - controller divides system clock by rate bits
// - controller data write starts byte, done after eight
// - done cleared by vector or status-then-data
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

// register offsets
`define SPC_OFS_CTRL      4'h0
`define SPC_OFS_STAT      4'h1
`define SPC_OFS_DATA      4'h2
`define SPC_OFS_MASK      4'h3
`define SPC_OFS_EVT       4'h4
`define SPC_OFS_CFG       4'h5

// control field positions
`define SPC_CTRL_IRQ_EN   7
`define SPC_CTRL_EN       6
`define SPC_CTRL_LSBF     5
`define SPC_CTRL_CTL      4
`define SPC_CTRL_CLK_IDLE_LEVEL     3
`define SPC_CTRL_CLK_PHASE_SEL     2
`define SPC_CTRL_RATE_HI  1
`define SPC_CTRL_RATE_LO  0

// status field positions
`define SPC_STAT_FLAG     7
`define SPC_STAT_WCOL     6
`define SPC_STAT_DBL      0

// event bits, config bit
`define SPC_EVT_DONE      0
`define SPC_EVT_FAULT     1
`define SPC_CFG_SS_IN     0

// reset values
`define SPC_CTRL_RST      8'h00
`define SPC_BYTE_RST      8'h00
`define SPC_SYNC_RST      4'h8

// half-period counts minus one, per divider (rate_double, rate bits)
`define SPC_HALF_DIV4     6'h01
`define SPC_HALF_DIV16    6'h07
`define SPC_HALF_DIV64    6'h1F
`define SPC_HALF_DIV128   6'h3F
`define SPC_HALF_DIV2     6'h00
`define SPC_HALF_DIV8     6'h03
`define SPC_HALF_DIV32    6'h0F

// clock edges per byte minus one
`define SPC_LAST_EDGE     4'hF

// pin index inside the synchroniser
`define SPC_PIN_SCK       0
`define SPC_PIN_MOSI      1
`define SPC_PIN_MISO      2
`define SPC_PIN_SS_N      3

`endif

// ===== spc_peer.sv
`timescale 1ns/1ns
module spc_peer (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    input  wire logic       lsb,
    input  wire logic       clk_phase_sel,
    input  wire logic [7:0] tx,
    output logic            miso,
    output logic      [7:0] rx
);
    int   e = 0; // clock edges in frame
    int   k = 0; // index of bit on line
    logic cur;   // bit being presented
    // select restarts the frame
    always @(negedge sel_n) begin
        e = 0;
        k = 0;
        rx = 8'h00;
    end
    always @(sck) begin
        if (!sel_n) begin
            if (e % 2 == clk_phase_sel) rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
            else k = (clk_phase_sel ? e / 2 : (e + 1) / 2) % 8;
            e = e + 1;
        end
    end
    assign cur = lsb ? tx[k] : tx[7 - k];
    // released line shows inverse of the bit at index k
    assign miso = sel_n ? ~cur : cur;
endmodule

// ===== spc_pins_if.sv
`timescale 1ns/1ns
interface spc_pins_if;
    logic [3:0] raw;    // pin levels straight from the pads
    logic [3:0] synced; // same levels after two flops
    modport sync (input raw, output synced);
    modport core (output raw, input synced);
endinterface

// ===== spc_pkg.sv
package spc_pkg;
    // controller clock generator state
    typedef enum logic [1:0] {
        SPC_IDLE = 2'b01,
        SPC_RUN  = 2'b10
    } spc_state_t;
endpackage

// ===== spc_port.sv
`timescale 1ns/1ns
`include "spc_map.svh"
module spc_port (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       global_irq_en,
    input  wire logic       vector_taken,
    output logic            irq,
    input  wire logic       sck_in,
    output logic            sck_out,
    output logic            sck_oe,
    input  wire logic       mosi_in,
    output logic            mosi_out,
    output logic            mosi_oe,
    input  wire logic       miso_in,
    output logic            miso_out,
    output logic            miso_oe,
    input  wire logic       ss_n_in
);
    spc_pins_if pins ();

    // pad levels into the synchroniser
    assign pins.raw = {ss_n_in, miso_in, mosi_in, sck_in};

    spc_sync u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pins    (pins.sync)
    );

    // register state
    logic [7:0]              ctrl_q, ctrl_d;       // serial_port_control
    logic                    dbl_q, dbl_d;         // rate_double
    logic                    flag_q, flag_d;       // xfer_done_flag
    logic                    wcol_q, wcol_d;       // write collision flag
    logic                    arm_q, arm_d;         // status read with flag seen
    logic [7:0]              rx_buf_q, rx_buf_d;   // last received byte
    logic [1:0]              mask_q, mask_d;       // interrupt mask
    logic [1:0]              evt_q, evt_d;         // sticky events
    logic                    ss_in_q, ss_in_d;     // select pin is an input
    logic [7:0]              rdata_q, rdata_d;     // read answer
    logic                    irq_q, irq_d;         // interrupt level
    // shift engine state
    spc_pkg::spc_state_t     state_q, state_d;     // clock generator
    logic [5:0]              div_q, div_d;         // half-period counter
    logic                    sck_q, sck_d;         // driven serial clock
    logic                    sck_prev_q, sck_prev_d; // last synced clock level
    logic [3:0]              cnt_q, cnt_d;         // clock edges seen
    logic [7:0]              tx_q, tx_d;           // outgoing bits
    logic [7:0]              rx_q, rx_d;           // incoming bits
    logic                    out_q, out_d;         // bit on the data line
    logic [1:0]              smp_q, smp_d;         // controller sample strobe, delayed
    logic [1:0]              lst_q, lst_d;         // controller byte end, delayed

    // decoded control fields
    logic       en, ctl, lsbf, clk_idle_level, clk_phase_sel;
    logic [5:0] half_m1;       // selected half period minus one
    logic       sck_s, ss_s, in_bit;
    logic       tgt_active;    // target selected and enabled
    logic       tick, lead, trail, sample, setup, last;
    logic       busy, fault;
    logic       smp_eff, lst_eff; // sample and byte end as applied
    logic [7:0] rx_next;

    assign en    = ctrl_q[`SPC_CTRL_EN];
    assign ctl   = ctrl_q[`SPC_CTRL_CTL];
    assign lsbf  = ctrl_q[`SPC_CTRL_LSBF];
    assign clk_idle_level  = ctrl_q[`SPC_CTRL_CLK_IDLE_LEVEL];
    assign clk_phase_sel  = ctrl_q[`SPC_CTRL_CLK_PHASE_SEL];
    assign sck_s = pins.synced[`SPC_PIN_SCK];
    assign ss_s  = pins.synced[`SPC_PIN_SS_N];

    // divider choice per rate bits
    always_comb begin
        unique case ({dbl_q, ctrl_q[`SPC_CTRL_RATE_HI], ctrl_q[`SPC_CTRL_RATE_LO]})
            3'h0: half_m1 = `SPC_HALF_DIV4;
            3'h1: half_m1 = `SPC_HALF_DIV16;
            3'h2: half_m1 = `SPC_HALF_DIV64;
            3'h3: half_m1 = `SPC_HALF_DIV128;
            3'h4: half_m1 = `SPC_HALF_DIV2;
            3'h5: half_m1 = `SPC_HALF_DIV8;
            3'h6: half_m1 = `SPC_HALF_DIV32;
            3'h7: half_m1 = `SPC_HALF_DIV64;
        endcase
    end

    // edge events from the generator or from the incoming clock
    always_comb begin
        tgt_active = en & ~ctl & ~ss_s;
        tick       = (state_q == spc_pkg::SPC_RUN) && (div_q == half_m1);
        // leading edge leaves the idle level
        if (ctl) begin
            lead  = en & tick & (sck_q == clk_idle_level);
            trail = en & tick & (sck_q != clk_idle_level);
        end else begin
            lead  = tgt_active & (clk_idle_level ? (~sck_s & sck_prev_q) : (sck_s & ~sck_prev_q));
            trail = tgt_active & (clk_idle_level ? (sck_s & ~sck_prev_q) : (~sck_s & sck_prev_q));
        end
        sample = clk_phase_sel ? trail : lead;
        setup  = clk_phase_sel ? (lead & (cnt_q != 4'h0)) : trail;
        last   = trail & (cnt_q == `SPC_LAST_EDGE);
        // controller input lags two flops behind its own clock, so sample late
        smp_eff = ctl ? smp_q[1] : sample;
        lst_eff = ctl ? lst_q[1] : last;
        // controller reads miso, target reads mosi
        in_bit = ctl ? pins.synced[`SPC_PIN_MISO] : pins.synced[`SPC_PIN_MOSI];
        rx_next = lsbf ? {in_bit, rx_q[7:1]} : {rx_q[6:0], in_bit};
        busy    = (state_q == spc_pkg::SPC_RUN) | (tgt_active & (cnt_q != 4'h0)) | (|lst_q);
        fault   = en & ctl & ss_in_q & ~ss_s;
    end

    // next values of all registers
    always_comb begin
        ctrl_d     = ctrl_q;
        dbl_d      = dbl_q;
        flag_d     = flag_q;
        wcol_d     = wcol_q;
        arm_d      = arm_q;
        rx_buf_d   = rx_buf_q;
        mask_d     = mask_q;
        evt_d      = evt_q;
        ss_in_d    = ss_in_q;
        rdata_d    = 8'h00;
        state_d    = state_q;
        div_d      = div_q;
        sck_d      = sck_q;
        sck_prev_d = sck_s;
        cnt_d      = cnt_q;
        tx_d       = tx_q;
        rx_d       = rx_q;
        smp_d      = {smp_q[0], ctl & sample};
        lst_d      = {lst_q[0], ctl & last};

        // flag clears come first so a same-cycle set wins
        // vector taken clears the flag
        if (vector_taken) begin
            flag_d = 1'b0;
        end
        // status read arms, data access clears
        if ((reg_rd | reg_wr) && (reg_addr == `SPC_OFS_DATA) && arm_q) begin
            flag_d = 1'b0;
            wcol_d = 1'b0;
            arm_d  = 1'b0;
        end
        if (reg_rd && (reg_addr == `SPC_OFS_STAT) && (flag_q | wcol_q)) begin
            arm_d = 1'b1;
        end

        // register writes
        if (reg_wr) begin
            unique case (reg_addr)
                `SPC_OFS_CTRL: ctrl_d = reg_wdata;
                `SPC_OFS_STAT: dbl_d = reg_wdata[`SPC_STAT_DBL];
                `SPC_OFS_DATA: begin
                    if (busy) begin
                        // write during a byte is refused
                        wcol_d = 1'b1;
                    end else begin
                        tx_d = reg_wdata;
                        cnt_d = 4'h0;
                        if (en & ctl) begin
                            state_d = spc_pkg::SPC_RUN;
                            div_d   = 6'h00;
                        end
                    end
                end
                `SPC_OFS_MASK: mask_d = reg_wdata[1:0];
                `SPC_OFS_EVT:  evt_d = evt_q & ~reg_wdata[1:0];
                `SPC_OFS_CFG:  ss_in_d = reg_wdata[`SPC_CFG_SS_IN];
                default: begin
                    // unmapped write ignored
                end
            endcase
        end

        // register reads, answer in the next cycle
        if (reg_rd) begin
            unique case (reg_addr)
                `SPC_OFS_CTRL: rdata_d = ctrl_q;
                `SPC_OFS_STAT: rdata_d = {flag_q, wcol_q, 5'h00, dbl_q};
                `SPC_OFS_DATA: rdata_d = rx_buf_q;
                `SPC_OFS_MASK: rdata_d = {6'h00, mask_q};
                `SPC_OFS_EVT:  rdata_d = {6'h00, evt_q};
                `SPC_OFS_CFG:  rdata_d = {7'h00, ss_in_q};
                default:       rdata_d = 8'h00;
            endcase
        end

        // clock generator divider
        if (state_q == spc_pkg::SPC_RUN) begin
            div_d = tick ? 6'h00 : div_q + 6'h01;
            if (tick) begin
                sck_d = ~sck_q;
            end
        end

        // shift engine
        if (lead | trail) begin
            cnt_d = cnt_q + 4'h1;
        end
        if (smp_eff) begin
            rx_d = rx_next;
        end
        if (setup) begin
            tx_d = lsbf ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
        end
        if (last) begin
            // clock stops at the sixteenth edge
            state_d  = spc_pkg::SPC_IDLE;
            cnt_d    = 4'h0;
        end
        if (lst_eff) begin
            rx_buf_d = smp_eff ? rx_next : rx_q;
            flag_d   = 1'b1;
            evt_d[`SPC_EVT_DONE] = 1'b1;
        end

        // deselected target holds counter in reset
        if (~ctl & ss_s) begin
            cnt_d = 4'h0;
            rx_d  = 8'h00;
        end

        if (fault) begin
            ctrl_d[`SPC_CTRL_CTL] = 1'b0;
            flag_d  = 1'b1;
            evt_d[`SPC_EVT_FAULT] = 1'b1;
            state_d = spc_pkg::SPC_IDLE;
            cnt_d   = 4'h0;
            smp_d   = 2'h0;
            lst_d   = 2'h0;
        end

        if (~en) begin
            state_d = spc_pkg::SPC_IDLE;
            cnt_d   = 4'h0;
            smp_d   = 2'h0;
            lst_d   = 2'h0;
        end
        if (state_d == spc_pkg::SPC_IDLE) begin
            sck_d = ctrl_d[`SPC_CTRL_CLK_IDLE_LEVEL];
        end

        // data line bit follows the shifter
        out_d = lsbf ? tx_d[0] : tx_d[7];

        irq_d = (ctrl_d[`SPC_CTRL_IRQ_EN] & flag_d & global_irq_en) | (|(evt_d & mask_d));
    end

    // register all state
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_q     <= `SPC_CTRL_RST;
            dbl_q      <= 1'b0;
            flag_q     <= 1'b0;
            wcol_q     <= 1'b0;
            arm_q      <= 1'b0;
            rx_buf_q   <= `SPC_BYTE_RST;
            mask_q     <= 2'h0;
            evt_q      <= 2'h0;
            ss_in_q    <= 1'b0;
            rdata_q    <= 8'h00;
            irq_q      <= 1'b0;
            state_q    <= spc_pkg::SPC_IDLE;
            div_q      <= 6'h00;
            sck_q      <= 1'b0;
            sck_prev_q <= 1'b0;
            cnt_q      <= 4'h0;
            tx_q       <= `SPC_BYTE_RST;
            rx_q       <= `SPC_BYTE_RST;
            out_q      <= 1'b0;
            smp_q      <= 2'h0;
            lst_q      <= 2'h0;
        end else begin
            ctrl_q     <= ctrl_d;
            dbl_q      <= dbl_d;
            flag_q     <= flag_d;
            wcol_q     <= wcol_d;
            arm_q      <= arm_d;
            rx_buf_q   <= rx_buf_d;
            mask_q     <= mask_d;
            evt_q      <= evt_d;
            ss_in_q    <= ss_in_d;
            rdata_q    <= rdata_d;
            irq_q      <= irq_d;
            state_q    <= state_d;
            div_q      <= div_d;
            sck_q      <= sck_d;
            sck_prev_q <= sck_prev_d;
            cnt_q      <= cnt_d;
            tx_q       <= tx_d;
            rx_q       <= rx_d;
            out_q      <= out_d;
            smp_q      <= smp_d;
            lst_q      <= lst_d;
        end
    end

    // pin drivers
    assign reg_rdata = rdata_q;
    assign irq       = irq_q;
    assign sck_out   = sck_q;
    assign mosi_out  = out_q;
    assign miso_out  = out_q;
    assign sck_oe    = en & ctl;
    assign mosi_oe   = en & ctl;
    assign miso_oe   = tgt_active;
endmodule

// ===== spc_sync.sv
`timescale 1ns/1ns
`include "spc_map.svh"
module spc_sync (
    input  wire logic ref_clk,
    input  wire logic rst,
    spc_pins_if.sync  pins
);
    logic [3:0] meta_q;   // first stage, read only by second stage
    logic [3:0] meta_d;
    logic [3:0] stab_q;   // second stage, safe for logic
    logic [3:0] stab_d;

    assign pins.synced = stab_q;

    // one two-flop chain per pin
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_bit
            always_comb begin
                meta_d[i] = pins.raw[i];
                stab_d[i] = meta_q[i];
            end
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    meta_q[i] <= 1'(`SPC_SYNC_RST >> i);
                    stab_q[i] <= 1'(`SPC_SYNC_RST >> i);
                end else begin
                    meta_q[i] <= meta_d[i];
                    stab_q[i] <= stab_d[i];
                end
            end
        end
    endgenerate
endmodule

// ===== testbench.sv
`timescale 1ns/1ns
module testbench;
    logic        ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic  [3:0] reg_addr = 4'h0;
    logic  [7:0] reg_wdata = 8'h00, reg_rdata, p_tx = 8'h00, p_rx, tx, rx;
    logic        global_irq_en = 1'b1, vector_taken = 1'b0, ss_n_in = 1'b1;
    logic        irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, sck_l;
    logic        tb_sck = 1'b0, tb_mosi = 1'b0; // bench-driven pads
    logic        p_sel_n = 1'b1, p_lsb = 1'b0, p_clk_phase_sel = 1'b0, p_miso;
    wire         sck_w = sck_oe ? sck_out : tb_sck; // resolved pad levels
    wire         mosi_w = mosi_oe ? mosi_out : tb_mosi;
    wire         miso_w = miso_oe ? miso_out : p_miso;
    integer      seed = 32'hA4BA;
    int          bad_count = 0, checks_done = 0, n_edge = 0, i;
    int          dv[8] = '{4, 16, 64, 128, 2, 8, 32, 64}; // divider per rate code
    logic [15:0] v, m;
    time         t_first, t_last;
    always #50 ref_clk = ~ref_clk;
    spc_port DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .global_irq_en(global_irq_en),
        .vector_taken(vector_taken), .irq(irq), .sck_in(sck_w), .sck_out(sck_out),
        .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
        .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n_in));
    spc_peer u_peer (.sck(sck_w), .mosi(mosi_w), .sel_n(p_sel_n), .lsb(p_lsb),
        .clk_phase_sel(p_clk_phase_sel), .tx(p_tx), .miso(p_miso), .rx(p_rx));
    // time the controller clock edges
    always @(posedge ref_clk) begin
        if (sck_oe && sck_out !== sck_l) begin
            if (n_edge == 0) t_first = $time;
            t_last = $time;
            n_edge = n_edge + 1;
        end
        sck_l <= sck_out;
    end
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        v = {8'h00, reg_rdata};
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // target frame at the link rate, mode zero
    task frame(input logic [7:0] d);
        for (int k = 7; k >= 0; k--) begin
            @(posedge ref_clk) tb_mosi <= d[k];
            repeat (3) @(posedge ref_clk);
            tb_sck <= 1'b1;
            m = {m[14:0], miso_out};
            repeat (4) @(posedge ref_clk);
            tb_sck <= 1'b0;
        end
    endtask
    task finish_test;
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge ref_clk);
        bad_count++;
        finish_test;
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        for (i = 0; i < 8; i++) begin
            rd(i[3:0]);
            chk(v, 16'h0000);
        end
        tx = $random(seed);
        wr(4'h0, tx);
        wr(4'h7, 8'hFF);
        rd(4'h0);
        chk(v, {8'h00, tx});
        rd(4'h7);
        chk(v, 16'h0000);
        wr(4'h0, 8'h10);
        wr(4'h2, 8'hA5);
        repeat (40) @(posedge ref_clk);
        rd(4'h1);
        chk(v, 16'h0000);
        // every rate, mode and order as controller
        for (i = 0; i < 8; i++) begin
            global_irq_en <= (i != 5);
            wr(4'h1, {7'h00, i[2]});
            wr(4'h0, {i[0], 1'b1, i[1], 1'b1, i[1:0], i[1:0]});
            repeat (3) @(posedge ref_clk);
            tx = $random(seed);
            p_tx = $random(seed);
            p_lsb = i[1];
            p_clk_phase_sel = i[0];
            p_sel_n = 1'b0;
            n_edge = 0;
            wr(4'h2, tx);
            if (i == 3) wr(4'h2, ~tx);
            v = 16'h0000;
            for (int n = 0; n < 1500 && !v[7]; n++) rd(4'h1);
            chk(v, {8'h00, 1'b1, i == 3, 5'h00, i[2]});
            chk({8'h00, p_rx}, {8'h00, tx});
            chk(16'(n_edge), 16'h0010);
            chk(16'((t_last - t_first) / 100), 16'(15 * dv[i] / 2));
            chk({15'h0000, irq}, {15'h0000, i[0] && i != 5});
            p_sel_n = 1'b1;
            if (i[0]) begin
                @(posedge ref_clk) vector_taken <= 1'b1;
                @(posedge ref_clk) vector_taken <= 1'b0;
                rd(4'h1);
                chk(v, {8'h00, 1'b0, i == 3, 5'h00, i[2]});
            end
            rd(4'h2);
            chk(v, {8'h00, p_tx});
            rd(4'h1);
            chk(v, {15'h0000, i[2]});
            chk({15'h0000, irq}, 16'h0000);
        end
        // select fault while controller
        wr(4'h4, 8'hFF);
        wr(4'h5, 8'h01);
        wr(4'h0, 8'h50);
        ss_n_in <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rd(4'h0);
        chk(v, 16'h0040);
        rd(4'h1);
        chk(v, 16'h0081);
        rd(4'h4);
        chk(v & 16'h0002, 16'h0002);
        wr(4'h3, 8'h02);
        repeat (2) @(posedge ref_clk);
        chk({15'h0000, irq}, 16'h0001);
        wr(4'h4, 8'h02);
        rd(4'h4);
        chk(v & 16'h0002, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        ss_n_in <= 1'b1;
        repeat (4) @(posedge ref_clk);
        wr(4'h0, 8'h50);
        rd(4'h0);
        chk(v, 16'h0050);
        rd(4'h2);
        wr(4'h3, 8'h00);
        wr(4'h5, 8'h00);
        // target: deselected clocks, then a real frame
        wr(4'h0, 8'h40);
        tx = $random(seed);
        rx = $random(seed);
        wr(4'h2, tx);
        frame(rx);
        repeat (6) @(posedge ref_clk);
        rd(4'h1);
        chk(v, 16'h0001);
        ss_n_in <= 1'b0;
        repeat (4) @(posedge ref_clk);
        frame(rx);
        repeat (6) @(posedge ref_clk);
        ss_n_in <= 1'b1;
        chk({8'h00, m[7:0]}, {8'h00, tx});
        rd(4'h1);
        chk(v, 16'h0081);
        rd(4'h2);
        chk(v, {8'h00, rx});
        finish_test;
    end
endmodule
